// File: pkg/reset_state_control_defines.svh
// register offsets, field positions, reset values and timing counts of the reset state block
`ifndef RESET_STATE_CONTROL_DEFINES_SVH
`define RESET_STATE_CONTROL_DEFINES_SVH

// ============================================================
// register offsets (byte addresses)
`define RSC_WDT_CTRL_OFFSET   8'h00
`define RSC_RST_FLAGS_OFFSET  8'h04
`define RSC_STATUS_OFFSET     8'h08
`define RSC_WDT_COUNT_OFFSET  8'h0c

// ============================================================
// watchdog control layout and reset value
`define RSC_WDT_CTRL_RESET    8'h53
`define RSC_EN_FIELD_MSB      7
`define RSC_EN_FIELD_LSB      3
`define RSC_SEL_MSB           2
`define RSC_EN_GOOD_A         5'h0a
`define RSC_EN_GOOD_B         5'h15

// ============================================================
// reset flag and status layout
`define RSC_FLAG_CTRLW_BIT    0
`define RSC_FLAG_SUPPLY_BIT   2
`define RSC_STAT_TO_BIT       0
`define RSC_STAT_PD_BIT       1
`define RSC_STAT_WDT_EN_BIT   2
`define RSC_STAT_WAIT_BIT     3
`define RSC_STAT_CAUSE_LSB    4
`define RSC_STAT_CAUSE_MSB    6

// ============================================================
// counts
`define RSC_WDT_WIDTH         18
`define RSC_SRESET_CYCLES     16
`define RSC_DROP_QUAL_CYCLES  4

`endif

// File: pkg/reset_state_control_pkg.sv
// types shared by the reset state block and its bench
package reset_state_control_pkg;

  typedef enum logic [1:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_IDLE,
    MODE_SLEEP
  } run_mode_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON,
    CAUSE_SUPPLY_DROP,
    CAUSE_WDT_RUN,
    CAUSE_WDT_LOW_POWER,
    CAUSE_CTRL_WRITE
  } reset_cause_t;

  typedef enum logic [0:0] {
    SEQ_RUN,
    SEQ_SRESET_WAIT
  } seq_state_t;

  // one-cycle reset commands to the core and peripherals
  typedef struct packed {
    logic pc_zero;
    logic sp_top;
    logic sp_zero;
    logic regs_init;
    logic int_disable;
    logic wdt_tb_clear;
    logic timers_off;
    logic ports_input;
  } reset_actions_t;

  typedef struct packed {
    logic timeout;
    logic power_down;
  } reset_flags_t;

endpackage

// File: src/reset_state_control.sv
// reset cause decoding, status flags, watchdog and apb register file
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "reset_state_control_defines.svh"

// Operation
// RL1 - watchdog time-out in fast or slow mode acts as power-on reset, time-out flag set
// RL2 - watchdog time-out in idle or sleep clears only pc and sp, sets time-out flag
// RL3 - supply-drop reset in fast or slow mode keeps time-out and power-down flags
// RL4 - run-mode watchdog reset sets time-out flag, keeps power-down flag
// RL5 - low-power watchdog reset sets both time-out and power-down flags
// RL6 - power-on reset disables every interrupt enable
// RL7 - power-on reset clears watchdog and time bases; watchdog counts at once
// RL8 - power-on reset turns every timer module off
// RL9 - power-on reset makes every port pin an input
// RL10 - power-on reset points stack pointer at top of return stack
// RL11 - power-on reset loads zero into program counter
// RL12 - qualified supply-drop reset sets its flag; only software clears it (the code also clears it on power-on reset)
// RL13 - invalid watchdog enable code resets after a delay and sets write flag
// RL14 - power-on reset clears time-out and power-down flags

module reset_state_control #(
  parameter int SRESET_CYCLES    = `RSC_SRESET_CYCLES,
  parameter int DROP_QUAL_CYCLES = `RSC_DROP_QUAL_CYCLES
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    srst_i,
  input  wire reset_state_control_pkg::run_mode_t      run_mode_i,
  input  wire logic                                    lirc_tick_i,
  input  wire logic                                    clr_wdt_i,
  input  wire logic                                    halt_i,
  input  wire logic                                    supply_low_i,
  input  wire logic                                    psel_i,
  input  wire logic                                    penable_i,
  input  wire logic                                    pwrite_i,
  input  wire logic [7:0]                              paddr_i,
  input  wire logic [31:0]                             pwdata_i,
  output logic      [31:0]                             prdata_o,
  output logic                                         pready_o,
  output logic                                         pslverr_o,
  output reset_state_control_pkg::reset_actions_t      reset_actions_o,
  output reset_state_control_pkg::reset_flags_t        flags_o,
  output logic                                         wdt_enabled_o
);
  import reset_state_control_pkg::*;

  localparam int WDT_W = `RSC_WDT_WIDTH;
  localparam int LQW   = $clog2(DROP_QUAL_CYCLES + 1);
  localparam int SR_BOUND = SRESET_CYCLES + 2;
  localparam reset_actions_t POR_ACTIONS = '{pc_zero: 1'b1, sp_top: 1'b1, sp_zero: 1'b0,
                                             regs_init: 1'b1, int_disable: 1'b1,
                                             wdt_tb_clear: 1'b1, timers_off: 1'b1,
                                             ports_input: 1'b1};
  localparam reset_actions_t LOWPOW_ACTIONS = '{pc_zero: 1'b1, sp_zero: 1'b1, default: 1'b0};

  // ============================================================
  // functions
  function automatic logic en_code_ok(input logic [7:0] ctrl);
    logic [4:0] f;
    f = ctrl[`RSC_EN_FIELD_MSB:`RSC_EN_FIELD_LSB];
    return (f == `RSC_EN_GOOD_A) || (f == `RSC_EN_GOOD_B);
  endfunction

  function automatic logic [WDT_W-1:0] wdt_limit(input logic [2:0] sel);
    logic [4:0] sh;
    case (sel)
      3'h0:    sh = 5'd8;
      3'h1:    sh = 5'd10;
      3'h2:    sh = 5'd12;
      3'h3:    sh = 5'd14;
      3'h4:    sh = 5'd15;
      3'h5:    sh = 5'd16;
      3'h6:    sh = 5'd17;
      default: sh = 5'd18;
    endcase
    return {WDT_W{1'b1}} >> (5'(WDT_W) - sh);
  endfunction

  // ============================================================
  // state
  logic [7:0]        wdt_ctrl_reg;
  logic [WDT_W-1:0]  wdt_cnt_reg;
  logic [LQW-1:0]    drop_cnt_reg;
  logic [15:0]       sreset_cnt_reg;
  seq_state_t        seq_reg;
  logic              timeout_reg;
  logic              pd_flag_reg;
  logic              supply_flag_reg;
  logic              ctrlw_flag_reg;
  reset_cause_t      cause_reg;
  reset_actions_t    actions_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              wdt_en_reg;

  // ============================================================
  // event decode
  logic low_power;
  logic wdt_en;
  logic wdt_timeout;
  logic drop_event;
  logic wdt_run_event;
  logic wdt_lp_event;
  logic ctrl_event;
  logic full_rst;
  logic apb_wr;
  logic bad_ctrl_wr;
  logic mapped;

  assign low_power   = (run_mode_i == MODE_IDLE) || (run_mode_i == MODE_SLEEP);
  assign wdt_en      = en_code_ok(wdt_ctrl_reg);
  assign wdt_timeout = wdt_en && lirc_tick_i &&
                       (wdt_cnt_reg == wdt_limit(wdt_ctrl_reg[`RSC_SEL_MSB:0]));
  // short dips are ignored; detector is off in idle and sleep
  assign drop_event  = supply_low_i && !low_power &&
                       (drop_cnt_reg == LQW'(DROP_QUAL_CYCLES - 1));
  assign wdt_run_event = wdt_timeout && !low_power && !drop_event;
  assign wdt_lp_event  = wdt_timeout && low_power;
  assign ctrl_event    = (seq_reg == SEQ_SRESET_WAIT) && (sreset_cnt_reg == 16'h0000) &&
                         !drop_event && !wdt_timeout;
  assign full_rst      = drop_event || wdt_run_event || ctrl_event;

  assign mapped = (paddr_i == `RSC_WDT_CTRL_OFFSET) || (paddr_i == `RSC_RST_FLAGS_OFFSET) ||
                  (paddr_i == `RSC_STATUS_OFFSET) || (paddr_i == `RSC_WDT_COUNT_OFFSET);
  assign apb_wr = psel_i && penable_i && pready_reg && pwrite_i && mapped;
  assign bad_ctrl_wr = apb_wr && (paddr_i == `RSC_WDT_CTRL_OFFSET) && !en_code_ok(pwdata_i[7:0]);

  // ============================================================
  // supply-drop qualification
  always_ff @(posedge clk_i) begin
    if (srst_i || !supply_low_i || low_power) begin
      drop_cnt_reg <= '0;
    end else if (drop_cnt_reg != LQW'(DROP_QUAL_CYCLES)) begin
      drop_cnt_reg <= drop_cnt_reg + LQW'(1);
    end
  end

  // ============================================================
  // watchdog control register and counter
  always_ff @(posedge clk_i) begin
    if (srst_i || full_rst) begin
      wdt_ctrl_reg <= `RSC_WDT_CTRL_RESET;
    end else if (apb_wr && paddr_i == `RSC_WDT_CTRL_OFFSET && seq_reg == SEQ_RUN) begin
      wdt_ctrl_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || full_rst || wdt_lp_event || clr_wdt_i || halt_i || bad_ctrl_wr) begin
      wdt_cnt_reg <= '0; // RL7
    end else if (wdt_en && lirc_tick_i) begin
      wdt_cnt_reg <= wdt_cnt_reg + WDT_W'(1); // RL7
    end
  end

  // ============================================================
  // delayed reset after an invalid enable code
  always_ff @(posedge clk_i) begin
    if (srst_i || full_rst || wdt_lp_event) begin
      seq_reg        <= SEQ_RUN;
      sreset_cnt_reg <= 16'h0000;
    end else begin
      case (seq_reg)
        SEQ_RUN: begin
          if (bad_ctrl_wr) begin
            seq_reg        <= SEQ_SRESET_WAIT; // RL13
            sreset_cnt_reg <= 16'(SRESET_CYCLES - 1);
          end
        end
        SEQ_SRESET_WAIT: begin
          if (sreset_cnt_reg != 16'h0000) begin
            sreset_cnt_reg <= sreset_cnt_reg - 16'h0001;
          end
        end
        default: begin
          seq_reg <= SEQ_RUN;
        end
      endcase
    end
  end

  // ============================================================
  // time-out and power-down flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timeout_reg <= 1'b0; // RL14
    end else if (wdt_run_event || wdt_lp_event) begin
      timeout_reg <= 1'b1; // RL1 RL2 RL4 RL5
    end else if (clr_wdt_i || halt_i) begin
      timeout_reg <= 1'b0;
    end
  end

  // supply-drop and run-mode watchdog resets leave power-down untouched
  always_ff @(posedge clk_i) begin // RL3 RL4
    if (srst_i) begin
      pd_flag_reg <= 1'b0; // RL14
    end else if (wdt_lp_event || halt_i) begin
      pd_flag_reg <= 1'b1; // RL5
    end else if (clr_wdt_i) begin
      pd_flag_reg <= 1'b0;
    end
  end

  // ============================================================
  // sticky reset flags: hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      supply_flag_reg <= 1'b0;
    end else if (drop_event) begin
      supply_flag_reg <= 1'b1; // RL12
    end else if (apb_wr && paddr_i == `RSC_RST_FLAGS_OFFSET &&
                 !pwdata_i[`RSC_FLAG_SUPPLY_BIT]) begin
      supply_flag_reg <= 1'b0; // RL12
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrlw_flag_reg <= 1'b0;
    end else if (ctrl_event) begin
      ctrlw_flag_reg <= 1'b1; // RL13
    end else if (apb_wr && paddr_i == `RSC_RST_FLAGS_OFFSET &&
                 !pwdata_i[`RSC_FLAG_CTRLW_BIT]) begin
      ctrlw_flag_reg <= 1'b0;
    end
  end

  // ============================================================
  // reset commands and last cause
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      actions_reg <= POR_ACTIONS; // RL6 RL7 RL8 RL9 RL10 RL11
      cause_reg   <= CAUSE_POWER_ON;
    end else if (drop_event) begin
      actions_reg <= POR_ACTIONS;
      cause_reg   <= CAUSE_SUPPLY_DROP;
    end else if (wdt_run_event) begin
      actions_reg <= POR_ACTIONS; // RL1
      cause_reg   <= CAUSE_WDT_RUN;
    end else if (wdt_lp_event) begin
      actions_reg <= LOWPOW_ACTIONS; // RL2
      cause_reg   <= CAUSE_WDT_LOW_POWER;
    end else if (ctrl_event) begin
      actions_reg <= POR_ACTIONS; // RL13
      cause_reg   <= CAUSE_CTRL_WRITE;
    end else begin
      actions_reg <= '0;
    end
  end

  // ============================================================
  // apb slave: data captured in setup, answered in first access cycle
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `RSC_WDT_CTRL_OFFSET:  rd_mux[7:0] = wdt_ctrl_reg;
      `RSC_RST_FLAGS_OFFSET: begin
        rd_mux[`RSC_FLAG_SUPPLY_BIT] = supply_flag_reg;
        rd_mux[`RSC_FLAG_CTRLW_BIT]  = ctrlw_flag_reg;
      end
      `RSC_STATUS_OFFSET: begin
        rd_mux[`RSC_STAT_TO_BIT]     = timeout_reg;
        rd_mux[`RSC_STAT_PD_BIT]     = pd_flag_reg;
        rd_mux[`RSC_STAT_WDT_EN_BIT] = wdt_en;
        rd_mux[`RSC_STAT_WAIT_BIT]   = (seq_reg == SEQ_SRESET_WAIT);
        rd_mux[`RSC_STAT_CAUSE_MSB:`RSC_STAT_CAUSE_LSB] = cause_reg;
      end
      `RSC_WDT_COUNT_OFFSET: rd_mux[WDT_W-1:0] = wdt_cnt_reg;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel_i && !penable_i;
      pslverr_reg <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wdt_en_reg <= 1'b0;
    end else begin
      wdt_en_reg <= wdt_en;
    end
  end

  assign prdata_o        = prdata_reg;
  assign pready_o        = pready_reg;
  assign pslverr_o       = pslverr_reg;
  assign reset_actions_o = actions_reg;
  assign flags_o         = '{timeout: timeout_reg, power_down: pd_flag_reg};
  assign wdt_enabled_o   = wdt_en_reg;

  // ============================================================
  // checks
  sequence run_wdt_s;
    wdt_run_event;
  endsequence

  sequence lp_wdt_s;
    wdt_lp_event;
  endsequence

  sequence bad_write_s;
    bad_ctrl_wr && seq_reg == SEQ_RUN && !full_rst && !wdt_lp_event;
  endsequence

  chk_run_wdt_full: assert property (@(posedge clk_i) disable iff (srst_i) // RL1
    run_wdt_s |=> actions_reg == POR_ACTIONS && timeout_reg)
    else $error("run-mode watchdog reset not a full reset");

  chk_lowpow_pcsp: assert property (@(posedge clk_i) disable iff (srst_i) // RL2
    lp_wdt_s |=> actions_reg == LOWPOW_ACTIONS && timeout_reg)
    else $error("low-power watchdog reset touched more than pc and sp");

  chk_drop_keeps_flags: assert property (@(posedge clk_i) disable iff (srst_i) // RL3
    drop_event && !halt_i && !clr_wdt_i |=> $stable(timeout_reg) && $stable(pd_flag_reg))
    else $error("supply-drop reset changed time-out or power-down flag");

  chk_run_wdt_pd: assert property (@(posedge clk_i) disable iff (srst_i) // RL4
    run_wdt_s ##0 (!halt_i && !clr_wdt_i) |=> pd_flag_reg == $past(pd_flag_reg))
    else $error("run-mode watchdog reset changed power-down flag");

  chk_lowpow_flags: assert property (@(posedge clk_i) disable iff (srst_i) // RL5
    lp_wdt_s |=> timeout_reg && pd_flag_reg)
    else $error("low-power watchdog reset did not set both flags");

  chk_por_actions: assert property (@(posedge clk_i) // RL6 RL7 RL8 RL9 RL10 RL11
    srst_i ##1 !srst_i |-> actions_reg == POR_ACTIONS && wdt_cnt_reg == '0 ##1
      actions_reg == '0 || drop_event || wdt_timeout)
    else $error("power-on reset commands missing");

  chk_supply_flag: assert property (@(posedge clk_i) disable iff (srst_i) // RL12
    drop_event |=> supply_flag_reg && cause_reg == CAUSE_SUPPLY_DROP)
    else $error("supply-drop flag not set");

  chk_ctrl_write_rst: assert property (@(posedge clk_i) disable iff (srst_i) // RL13
    bad_write_s |-> ##[1:SR_BOUND] (actions_reg.regs_init && (ctrlw_flag_reg ||
      cause_reg != CAUSE_CTRL_WRITE)))
    else $error("invalid enable code did not reset in time");

  chk_por_flags: assert property (@(posedge clk_i) // RL14
    srst_i |=> !timeout_reg && !pd_flag_reg && !supply_flag_reg && !ctrlw_flag_reg)
    else $error("power-on reset left a flag set");

endmodule

// File: test/tb_reset_state_control.sv
// self-checking bench for the reset state block over its apb port
`timescale 1ns/1ps
`include "reset_state_control_defines.svh"

module tb_reset_state_control;
  import reset_state_control_pkg::*;

  logic           clk_i;
  logic           srst_i;
  run_mode_t      run_mode_i;
  logic           lirc_tick_i;
  logic           clr_wdt_i;
  logic           halt_i;
  logic           supply_low_i;
  logic           psel_i;
  logic           penable_i;
  logic           pwrite_i;
  logic [7:0]     paddr_i;
  logic [31:0]    pwdata_i;
  logic [31:0]    prdata_o;
  logic           pready_o;
  logic           pslverr_o;
  reset_actions_t reset_actions_o;
  reset_flags_t   flags_o;
  logic           wdt_enabled_o;
  logic [31:0]    rd;
  logic           er;
  int             failures;
  int             checks_done;

  reset_state_control #(
    .SRESET_CYCLES    (16),
    .DROP_QUAL_CYCLES (4)
  ) i_reset_state_control (
    .clk_i           (clk_i),
    .srst_i          (srst_i),
    .run_mode_i      (run_mode_i),
    .lirc_tick_i     (lirc_tick_i),
    .clr_wdt_i       (clr_wdt_i),
    .halt_i          (halt_i),
    .supply_low_i    (supply_low_i),
    .psel_i          (psel_i),
    .penable_i       (penable_i),
    .pwrite_i        (pwrite_i),
    .paddr_i         (paddr_i),
    .pwdata_i        (pwdata_i),
    .prdata_o        (prdata_o),
    .pready_o        (pready_o),
    .pslverr_o       (pslverr_o),
    .reset_actions_o (reset_actions_o),
    .flags_o         (flags_o),
    .wdt_enabled_o   (wdt_enabled_o)
  );

  // ============================================================
  // clock and common tasks
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // values are taken at the very edge that samples pready high
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] data, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
    end
    data      = prdata_o;
    err       = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, rd, er);
    check_eq(rd & mask, exp);
  endtask

  // one-cycle action pulse: poll each cycle, bounded
  task automatic wait_action(input logic [7:0] exp, input int limit);
    int n;
    n = 0;
    @(posedge clk_i);
    while (reset_actions_o === 8'h00 && n < limit) begin
      @(posedge clk_i);
      n++;
    end
    check_eq({24'h0, reset_actions_o}, {24'h0, exp});
  endtask

  // ============================================================
  // main sequence
  initial begin
    failures     = 0;
    checks_done  = 0;
    srst_i       = 1'b1;
    run_mode_i   = MODE_FAST;
    lirc_tick_i  = 1'b0;
    clr_wdt_i    = 1'b0;
    halt_i       = 1'b0;
    supply_low_i = 1'b0;
    psel_i       = 1'b0;
    penable_i    = 1'b0;
    pwrite_i     = 1'b0;
    paddr_i      = 8'h00;
    pwdata_i     = 32'h0;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    check_eq({24'h0, reset_actions_o}, 32'h0000_00df);
    check_eq({30'h0, flags_o}, 32'h0);
    rd_chk(`RSC_WDT_CTRL_OFFSET, 32'hff, 32'h53);
    check_eq({31'h0, wdt_enabled_o}, 32'h1);
    // run-mode time-out with power-down flag already set
    @(posedge clk_i);
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    apb_xfer(1'b1, `RSC_WDT_CTRL_OFFSET, 32'h50, rd, er);
    lirc_tick_i <= 1'b1;
    wait_action(8'hdf, 1000);
    check_eq({30'h0, flags_o}, 32'h3);
    lirc_tick_i <= 1'b0;
    rd_chk(`RSC_WDT_CTRL_OFFSET, 32'hff, 32'h53);
    rd_chk(`RSC_STATUS_OFFSET, 32'h7b, 32'h23);
    rd_chk(`RSC_WDT_COUNT_OFFSET, 32'h3_ffff, 32'h1);
    // low-power time-out leaves control alone
    apb_xfer(1'b1, `RSC_WDT_CTRL_OFFSET, 32'ha8, rd, er);
    clr_wdt_i <= 1'b1;
    @(posedge clk_i);
    clr_wdt_i  <= 1'b0;
    run_mode_i <= MODE_IDLE;
    @(posedge clk_i);
    check_eq({30'h0, flags_o}, 32'h0);
    lirc_tick_i <= 1'b1;
    wait_action(8'ha0, 1000);
    check_eq({30'h0, flags_o}, 32'h3);
    lirc_tick_i <= 1'b0;
    rd_chk(`RSC_WDT_CTRL_OFFSET, 32'hff, 32'ha8);
    rd_chk(`RSC_STATUS_OFFSET, 32'h7b, 32'h33);
    // supply drop in run mode keeps both flags
    run_mode_i   <= MODE_SLOW;
    supply_low_i <= 1'b1;
    wait_action(8'hdf, 50);
    check_eq({30'h0, flags_o}, 32'h3);
    supply_low_i <= 1'b0;
    rd_chk(`RSC_RST_FLAGS_OFFSET, 32'h05, 32'h04);
    rd_chk(`RSC_STATUS_OFFSET, 32'h7b, 32'h13);
    apb_xfer(1'b1, `RSC_RST_FLAGS_OFFSET, 32'h05, rd, er);
    rd_chk(`RSC_RST_FLAGS_OFFSET, 32'h05, 32'h04);
    apb_xfer(1'b1, `RSC_RST_FLAGS_OFFSET, 32'h00, rd, er);
    rd_chk(`RSC_RST_FLAGS_OFFSET, 32'h05, 32'h00);
    // bad enable code: delayed full reset and write flag
    apb_xfer(1'b1, `RSC_WDT_CTRL_OFFSET, 32'h00, rd, er);
    repeat (2) @(posedge clk_i);
    #1;
    check_eq({31'h0, wdt_enabled_o}, 32'h0);
    wait_action(8'hdf, 40);
    rd_chk(`RSC_RST_FLAGS_OFFSET, 32'h05, 32'h01);
    rd_chk(`RSC_STATUS_OFFSET, 32'h7b, 32'h43);
    // unmapped place answers with an error and zero data
    apb_xfer(1'b0, 8'h10, 32'h0, rd, er);
    check_eq(rd, 32'h0);
    check_eq({31'h0, er}, 32'h1);
    // second power-on clears flags that are set
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check_eq({30'h0, flags_o}, 32'h0);
    rd_chk(`RSC_RST_FLAGS_OFFSET, 32'h05, 32'h00);
    print_verdict();
  end

  // ============================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    print_verdict();
  end

endmodule
